/* design/lpm_pads.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
// Summary of operation
// [RL1] Serves LPDDR4 and LPDDR4x parts with a data bus of sixteen or thirty-two bits.
// [RL2] Two independent full-duplex AXI4 ports face the core logic; the code serves one read or one write at a time across both ports.
// [RL3] The memory pads are reached only through this controller, never directly.
// [RL4] A six-bit command/address bus is driven to the memory.
// [RL5] Four active-low chip selects are driven, one per rank or channel.
// [RL6] Two active-high clock enables are driven; dropping them idles the memory.
// [RL7] An active-low reset is driven; low holds the memory in reset.
// [RL8] The memory clock leaves as a true and complement pair in opposite phase.
// [RL9] The data bus is driven by this end for writes and by the memory for reads.
// [RL10] Strobes are differential pairs per byte, ours on writes, the memory's on reads.
// [RL11] Each byte lane has a two-way mask/inversion line, mask high or inversion flag.
// [RL12] With write inversion on, a lane's flag is high when its byte goes out inverted.
// [RL13] With read inversion on, the memory raises the flag of a byte it returns inverted.
// [RL14] One strobe pair per byte on writes, lane 0's strobe for all bytes on reads, one flag per byte; read inversion is undone.
// [RL15] In narrow mode the upper lanes stay undriven and their inputs are ignored.
module lpm_pads (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_wide,
	input wire logic i_dbi_wr_en,
	input wire logic i_dbi_rd_en,
	input wire logic [`LPM_CKE_W-1:0] i_cke_req,
	input wire logic i_mem_reset_req,
	input wire lpm_pkg::lpm_axi_req_t i_axi [2],
	output lpm_pkg::lpm_axi_rsp_t o_axi [2],
	input wire lpm_pkg::lpm_pad_in_t i_pad,
	output lpm_pkg::lpm_pad_out_t o_pad
);
	localparam logic [3:0] CK_HALF = 4'(`LPM_CK_HALF_CYC);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	lpm_pkg::lpm_state_t state_q, state_d;
	lpm_pkg::lpm_pad_out_t pad_q, pad_d;
	lpm_pkg::lpm_axi_rsp_t rsp_q [2];
	lpm_pkg::lpm_axi_rsp_t rsp_d [2];
	logic [3:0] div_q;
	logic port_q, port_d, last_q, last_d, wr_q, wr_d;
	logic [`LPM_ID_W-1:0] id_q, id_d;
	logic [`LPM_ADDR_W-1:0] addr_q, addr_d;
	logic [`LPM_LEN_W-1:0] len_q, len_d, beat_q, beat_d;
	logic [`LPM_DQ_W-1:0] wraw_q, wraw_d;
	// Synchronisers for the memory-driven pads
	logic dqs_s1, dqs_s2, dqs_s3;
	logic [`LPM_DQ_W-1:0] dq_s1, dq_s2;
	logic [`LPM_LANES-1:0] dm_s1, dm_s2;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire tick = (div_q == CK_HALF - 4'h1);
	wire rise = tick && !pad_q.mem_clock_true;
	wire [1:0] want = {i_axi[1].awvalid | i_axi[1].arvalid,
		i_axi[0].awvalid | i_axi[0].arvalid};
	// Rotate priority so neither port can starve the other
	wire pick = want[!last_q] ? !last_q : last_q;
	wire pick_wr = i_axi[pick].awvalid;
	wire [`LPM_LANES-1:0] lane_on = i_wide ? 4'hf : 4'h3; // RL1 RL15
	wire dqs_edge = dqs_s2 ^ dqs_s3;
	wire w_ok = i_axi[port_q].wvalid;
	wire b_done = rsp_q[port_q].bvalid && i_axi[port_q].bready;
	wire r_done = rsp_q[port_q].rvalid && i_axi[port_q].rready;
	logic [`LPM_DQ_W-1:0] w_out, r_in;
	logic [`LPM_LANES-1:0] w_inv;

	// ------------------------------------------------------------
	// Per-lane inversion
	// ------------------------------------------------------------
	// Each byte owns one flag and, on writes, one strobe pair; reads use lane 0's strobe
	for (genvar k = 0; k < `LPM_LANES; k++) begin : g_lane
		wire [7:0] wb = i_axi[port_q].wdata[8*k +: 8];
		wire [3:0] ones = 4'($countones(wb));
		assign w_inv[k] = i_dbi_wr_en && (ones > `LPM_DBI_ONES); // RL12
		assign w_out[8*k +: 8] = w_inv[k] ? ~wb : wb;
		// Undo the memory's inversion; upper lanes read zero when narrow
		assign r_in[8*k +: 8] = lane_on[k] ?
			(dq_s2[8*k +: 8] ^ {8{i_dbi_rd_en & dm_s2[k]}}) : 8'h00; // RL14 RL15
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		pad_d = pad_q;
		rsp_d = rsp_q;
		port_d = port_q;
		last_d = last_q;
		wr_d = wr_q;
		id_d = id_q;
		addr_d = addr_q;
		len_d = len_q;
		beat_d = beat_q;
		wraw_d = wraw_q;
		for (int p = 0; p < 2; p++) begin
			rsp_d[p].awready = 1'b0;
			rsp_d[p].arready = 1'b0;
			rsp_d[p].wready = 1'b0;
		end
		if (tick) begin
			pad_d.mem_clock_true = !pad_q.mem_clock_true; // RL8
			pad_d.mem_clock_comp = pad_q.mem_clock_true; // RL8
		end
		pad_d.cke = i_cke_req; // RL6
		pad_d.rst_n = !i_mem_reset_req; // RL7
		unique case (state_q)
			lpm_pkg::ST_IDLE: begin
				if (rise && want != 2'b00) begin
					port_d = pick;
					last_d = pick;
					wr_d = pick_wr;
					id_d = pick_wr ? i_axi[pick].awid : i_axi[pick].arid;
					addr_d = pick_wr ? i_axi[pick].awaddr : i_axi[pick].araddr;
					len_d = pick_wr ? i_axi[pick].awlen : i_axi[pick].arlen;
					beat_d = '0;
					rsp_d[pick].awready = pick_wr; // RL2
					rsp_d[pick].arready = !pick_wr; // RL2
					state_d = lpm_pkg::ST_CMD;
				end
			end
			lpm_pkg::ST_CMD: begin
				if (rise) begin
					pad_d.cs_n = ~(4'h1 << addr_q[31:30]); // RL5
					pad_d.ca = wr_q ? `LPM_CA_WRITE : `LPM_CA_READ; // RL4
					state_d = lpm_pkg::ST_ADDR;
				end
			end
			lpm_pkg::ST_ADDR: begin
				if (rise) begin
					pad_d.ca = addr_q[7:2]; // RL4
					state_d = wr_q ? lpm_pkg::ST_WRITE : lpm_pkg::ST_READ;
				end
			end
			lpm_pkg::ST_WRITE: begin
				if (rise) begin
					pad_d.cs_n = '1;
					pad_d.ca = `LPM_CA_IDLE;
					if (w_ok) begin
						// Only used lanes leave the pads; the rest float
						pad_d.dq_oe_n = ~{{8{lane_on[3]}}, {8{lane_on[2]}},
							{8{lane_on[1]}}, {8{lane_on[0]}}}; // RL9 RL15
						pad_d.dqs_oe_n = ~lane_on; // RL10
						pad_d.mask_oe_n = ~lane_on; // RL11
						pad_d.dq = w_out; // RL9
						pad_d.mem_mask_invert = i_dbi_wr_en ? w_inv :
							~i_axi[port_q].wstrb; // RL11 RL12
						wraw_d = i_axi[port_q].wdata;
						rsp_d[port_q].wready = 1'b1; // RL2
						beat_d = beat_q + 8'h01;
						if (beat_q == len_q || i_axi[port_q].wlast) begin
							state_d = lpm_pkg::ST_BRESP;
						end
					end else begin
						pad_d.dq_oe_n = '1;
						pad_d.dqs_oe_n = '1;
						pad_d.mask_oe_n = '1;
					end
				end
				pad_d.dqs_t = {4{pad_q.mem_clock_true}} & lane_on; // RL10
				pad_d.dqs_c = ~pad_d.dqs_t; // RL10
			end
			lpm_pkg::ST_BRESP: begin
				if (rise || b_done) begin // No lane may stay driven in idle
					pad_d.dq_oe_n = '1;
					pad_d.dqs_oe_n = '1;
					pad_d.mask_oe_n = '1;
					pad_d.dqs_t = '0;
					pad_d.dqs_c = '1;
				end
				rsp_d[port_q].bvalid = 1'b1; // RL2
				rsp_d[port_q].bid = id_q;
				rsp_d[port_q].bresp = `LPM_RESP_OKAY;
				if (b_done) begin
					rsp_d[port_q].bvalid = 1'b0;
					state_d = lpm_pkg::ST_IDLE;
				end
			end
			lpm_pkg::ST_READ: begin
				if (rise) begin
					pad_d.cs_n = '1;
					pad_d.ca = `LPM_CA_IDLE;
				end
				if (r_done) begin
					rsp_d[port_q].rvalid = 1'b0;
					if (rsp_q[port_q].rlast) begin
						state_d = lpm_pkg::ST_IDLE;
					end
				end
				// A new beat wins over the handshake that clears valid
				if (dqs_edge && beat_q <= len_q && !rsp_q[port_q].rlast) begin
					rsp_d[port_q].rvalid = 1'b1; // RL9
					rsp_d[port_q].rdata = r_in; // RL14
					rsp_d[port_q].rid = id_q;
					rsp_d[port_q].rresp = `LPM_RESP_OKAY;
					rsp_d[port_q].rlast = (beat_q == len_q);
					beat_d = beat_q + 8'h01;
				end
				if (r_done && rsp_q[port_q].rlast) begin
					rsp_d[port_q].rlast = 1'b0;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Idle pads: all lanes released, memory held in reset, clock low
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= lpm_pkg::ST_IDLE;
			pad_q <= '{ca: '0, cs_n: '1, cke: '0, rst_n: 1'b0,
				mem_clock_true: 1'b0, mem_clock_comp: 1'b1, dq: '0,
				dq_oe_n: '1, dqs_t: '0, dqs_c: '1, dqs_oe_n: '1,
				mem_mask_invert: '0, mask_oe_n: '1};
			rsp_q <= '{default: '0};
			div_q <= '0;
			{port_q, last_q, wr_q} <= '0;
			{id_q, addr_q, len_q, beat_q, wraw_q} <= '0;
		end else begin
			state_q <= state_d;
			pad_q <= pad_d;
			rsp_q <= rsp_d;
			div_q <= tick ? 4'h0 : div_q + 4'h1;
			{port_q, last_q, wr_q} <= {port_d, last_d, wr_d};
			{id_q, addr_q, len_q, beat_q, wraw_q} <=
				{id_d, addr_d, len_d, beat_d, wraw_d};
		end
	end

	// Memory-driven pads pass two flops before any logic reads them
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			{dqs_s1, dqs_s2, dqs_s3} <= '0;
			{dq_s1, dq_s2, dm_s1, dm_s2} <= '0;
		end else begin
			{dqs_s1, dqs_s2, dqs_s3} <= {i_pad.dqs_t[0], dqs_s1, dqs_s2};
			{dq_s1, dq_s2} <= {i_pad.dq, dq_s1};
			{dm_s1, dm_s2} <= {i_pad.mem_mask_invert, dm_s1};
		end
	end

	assign o_pad = pad_q; // RL3
	assign o_axi = rsp_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_cs_one;
		$countones(~pad_q.cs_n) <= 1;
	endproperty
	a_cs_one: assert property (p_cs_one) else $error("two ranks selected"); // RL5
	property p_ck_pair;
		pad_q.mem_clock_comp == !pad_q.mem_clock_true;
	endproperty
	a_ck_pair: assert property (p_ck_pair) else $error("clock pair in phase"); // RL8
	property p_narrow;
		!i_wide |=> pad_q.dq_oe_n[31:16] == 16'hffff && pad_q.dqs_oe_n[3:2] == 2'h3;
	endproperty
	a_narrow: assert property (p_narrow) else $error("upper lane driven"); // RL15
	property p_drive_wr;
		pad_q.dq_oe_n != '1 |-> state_q inside {lpm_pkg::ST_WRITE, lpm_pkg::ST_BRESP};
	endproperty
	a_drive_wr: assert property (p_drive_wr) else $error("data driven off write"); // RL9
	property p_dbi;
		i_dbi_wr_en && $stable(i_dbi_wr_en) && pad_q.mem_mask_invert[0]
			&& !pad_q.mask_oe_n[0] |-> pad_q.dq[7:0] == ~wraw_q[7:0];
	endproperty
	a_dbi: assert property (p_dbi) else $error("flag without inverted byte"); // RL12
	property p_rst;
		i_mem_reset_req |=> !pad_q.rst_n;
	endproperty
	a_rst: assert property (p_rst) else $error("memory reset not driven"); // RL7
	property p_cke;
		##1 pad_q.cke == $past(i_cke_req);
	endproperty
	a_cke: assert property (p_cke) else $error("clock enable lag"); // RL6
	sequence s_cmd;
		state_q == lpm_pkg::ST_CMD && rise;
	endsequence
	sequence s_ca_out;
		##1 pad_q.cs_n != '1 && pad_q.ca inside {`LPM_CA_WRITE, `LPM_CA_READ};
	endsequence
	property p_cmd;
		s_cmd |-> s_ca_out;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command not issued"); // RL4
	property p_bhold;
		rsp_q[0].bvalid && !i_axi[0].bready |=> rsp_q[0].bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped"); // RL2
	property p_dqs_lane;
		pad_q.dqs_oe_n == {pad_q.dq_oe_n[24], pad_q.dq_oe_n[16],
			pad_q.dq_oe_n[8], pad_q.dq_oe_n[0]};
	endproperty
	a_dqs_lane: assert property (p_dqs_lane) else $error("strobe lane mismatch"); // RL10
endmodule : lpm_pads
`default_nettype wire

/* design/lpm_defs.svh */
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
// Core clock and memory clock timing
`define LPM_CLK_PS 4000
`define LPM_CK_HALF_NS 8
`define LPM_CK_HALF_CYC ((`LPM_CK_HALF_NS * 1000 + `LPM_CLK_PS - 1) / `LPM_CLK_PS)
// Pad widths
`define LPM_CA_W 6
`define LPM_CS_W 4
`define LPM_CKE_W 2
`define LPM_DQ_W 32
`define LPM_LANES 4
`define LPM_NARROW_LANES 2
// AXI widths
`define LPM_ID_W 6
`define LPM_ADDR_W 32
`define LPM_LEN_W 8
// Command codes on the command/address bus
`define LPM_CA_WRITE 6'h04
`define LPM_CA_READ 6'h02
`define LPM_CA_IDLE 6'h00
// Data bus inversion threshold (ones in a byte)
`define LPM_DBI_ONES 4'h4
// Response codes
`define LPM_RESP_OKAY 2'h0
`endif

/* design/lpm_pkg.sv */
`include "lpm_defs.svh"
package lpm_pkg;
	// Core-side request of one AXI4 port
	typedef struct packed {
		logic awvalid;
		logic [`LPM_ID_W-1:0] awid;
		logic [`LPM_ADDR_W-1:0] awaddr;
		logic [`LPM_LEN_W-1:0] awlen;
		logic wvalid;
		logic [`LPM_DQ_W-1:0] wdata;
		logic [`LPM_LANES-1:0] wstrb;
		logic wlast;
		logic bready;
		logic arvalid;
		logic [`LPM_ID_W-1:0] arid;
		logic [`LPM_ADDR_W-1:0] araddr;
		logic [`LPM_LEN_W-1:0] arlen;
		logic rready;
	} lpm_axi_req_t;
	// Core-side response of one AXI4 port
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [`LPM_ID_W-1:0] bid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [`LPM_ID_W-1:0] rid;
		logic [`LPM_DQ_W-1:0] rdata;
		logic [1:0] rresp;
		logic rlast;
	} lpm_axi_rsp_t;
	// Pad outputs toward the memory; *_oe_n low while driving
	typedef struct packed {
		logic [`LPM_CA_W-1:0] ca;
		logic [`LPM_CS_W-1:0] cs_n;
		logic [`LPM_CKE_W-1:0] cke;
		logic rst_n;
		logic mem_clock_true;
		logic mem_clock_comp;
		logic [`LPM_DQ_W-1:0] dq;
		logic [`LPM_DQ_W-1:0] dq_oe_n;
		logic [`LPM_LANES-1:0] dqs_t;
		logic [`LPM_LANES-1:0] dqs_c;
		logic [`LPM_LANES-1:0] dqs_oe_n;
		logic [`LPM_LANES-1:0] mem_mask_invert;
		logic [`LPM_LANES-1:0] mask_oe_n;
	} lpm_pad_out_t;
	// Pad inputs from the memory
	typedef struct packed {
		logic [`LPM_DQ_W-1:0] dq;
		logic [`LPM_LANES-1:0] dqs_t;
		logic [`LPM_LANES-1:0] dqs_c;
		logic [`LPM_LANES-1:0] mem_mask_invert;
	} lpm_pad_in_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_WRITE, ST_BRESP, ST_READ
	} lpm_state_t;
endpackage : lpm_pkg

/* tb/lpm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
// ----------------------------------------
// Memory side of the pads, single-beat reads
// ----------------------------------------
module lpm_mem_model (
	input wire lpm_pkg::lpm_pad_out_t i_pad,
	input wire logic i_start,
	input wire logic [31:0] i_word,
	input wire logic [3:0] i_inv,
	output lpm_pkg::lpm_pad_in_t o_drv
);
	integer k;
	// One beat per start, strobe edge 31 ns after data is set and 62.5 ns before it changes
	initial begin
		o_drv = '0;
		o_drv.dqs_c = 4'hf;
		forever begin
			@(posedge i_start);
			wait (i_pad.ca == `LPM_CA_READ && i_pad.cs_n != 4'hf);
			wait (i_pad.cs_n == 4'hf);
			#20;
			for (k = 0; k < 4; k++) begin
				o_drv.dq[k*8 +: 8] = i_word[k*8 +: 8] ^ {8{i_inv[k]}};
			end
			o_drv.mem_mask_invert = i_inv;
			#31;
			o_drv.dqs_t = ~o_drv.dqs_t;
			o_drv.dqs_c = ~o_drv.dqs_t;
			#62.5;
			// Hold time over: lines no longer show the beat
			o_drv.dq = ~o_drv.dq;
			o_drv.mem_mask_invert = ~o_drv.mem_mask_invert;
		end
	end
endmodule : lpm_mem_model
`default_nettype wire

/* tb/tb_lpm_pads.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpm_defs.svh"
module tb_lpm_pads;
	logic i_clock, i_rst, i_wide, i_dbi_wr_en, i_dbi_rd_en, i_mem_reset_req;
	logic [1:0] i_cke_req;
	lpm_pkg::lpm_axi_req_t i_axi [2];
	lpm_pkg::lpm_axi_rsp_t o_axi [2];
	lpm_pkg::lpm_pad_in_t i_pad, mem_drv;
	lpm_pkg::lpm_pad_out_t o_pad;
	logic mem_start;
	logic [31:0] mem_word;
	logic [3:0] mem_inv;
	int num_errors = 0;
	int comparisons = 0;
	// ----------------------------------------
	// Instances and wire resolution
	// ----------------------------------------
	lpm_pads u_lpm_pads (.i_clock(i_clock), .i_rst(i_rst), .i_wide(i_wide),
		.i_dbi_wr_en(i_dbi_wr_en), .i_dbi_rd_en(i_dbi_rd_en),
		.i_cke_req(i_cke_req), .i_mem_reset_req(i_mem_reset_req),
		.i_axi(i_axi), .o_axi(o_axi), .i_pad(i_pad), .o_pad(o_pad));
	lpm_mem_model u_lpm_mem_model (.i_pad(o_pad), .i_start(mem_start),
		.i_word(mem_word), .i_inv(mem_inv), .o_drv(mem_drv));
	// Pins carry our value while our enable is low, else the memory's
	always_comb begin
		i_pad.dq = (o_pad.dq & ~o_pad.dq_oe_n) | (mem_drv.dq & o_pad.dq_oe_n);
		i_pad.dqs_t = (o_pad.dqs_t & ~o_pad.dqs_oe_n)
			| (mem_drv.dqs_t & o_pad.dqs_oe_n);
		i_pad.dqs_c = (o_pad.dqs_c & ~o_pad.dqs_oe_n)
			| (mem_drv.dqs_c & o_pad.dqs_oe_n);
		i_pad.mem_mask_invert = (o_pad.mem_mask_invert & ~o_pad.mask_oe_n)
			| (mem_drv.mem_mask_invert & o_pad.mask_oe_n);
	end
	initial begin
		i_clock = 0;
		forever #2 i_clock = ~i_clock;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic timed_out;
		num_errors++;
		$display("CHECK FAILED handshake expected done seen timeout");
		complete_run();
	endtask : timed_out
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_case;
		i_rst <= 1'b1;
		repeat (10) @(posedge i_clock);
		check("cs_n", o_pad.cs_n, 4'hf);
		check("cke", o_pad.cke, 2'h0);
		check("rst_n", o_pad.rst_n, 1'b0);
		check("dq_oe_n", o_pad.dq_oe_n, 32'hffff_ffff);
		i_rst <= 1'b0;
	endtask : reset_case
	task automatic ctrl_case;
		i_cke_req <= 2'h2;
		i_mem_reset_req <= 1'b0;
		repeat (2) @(posedge i_clock);
		check("cke", o_pad.cke, 2'h2);
		check("rst_n", o_pad.rst_n, 1'b1);
		i_mem_reset_req <= 1'b1;
		repeat (2) @(posedge i_clock);
		check("rst_n", o_pad.rst_n, 1'b0);
		i_mem_reset_req <= 1'b0;
		i_cke_req <= 2'h3;
	endtask : ctrl_case
	task automatic clock_case;
		int n;
		logic prev;
		n = 0;
		prev = o_pad.mem_clock_true;
		repeat (16) begin
			@(posedge i_clock);
			check("ck pair", o_pad.mem_clock_true ^ o_pad.mem_clock_comp, 1);
			n += (o_pad.mem_clock_true !== prev);
			prev = o_pad.mem_clock_true;
		end
		check("ck edges", n, 8);
	endtask : clock_case
	// Single-beat write; expectations worked out by the caller
	task automatic write_case(input int p, input logic wide, input logic dbi,
		input logic [31:0] exp_dq, input logic [3:0] exp_mask);
		logic [31:0] dq, oe, keep;
		logic [3:0] mk, mo, cs, so, lanes;
		logic [5:0] a;
		logic cmd, got;
		cmd = 0;
		got = 0;
		a = 0;
		keep = wide ? 32'hffff_ffff : 32'h0000_ffff;
		lanes = wide ? 4'hf : 4'h3;
		@(posedge i_clock);
		i_wide <= wide;
		i_dbi_wr_en <= dbi;
		i_axi[p].awvalid <= 1'b1;
		i_axi[p].awid <= 6'h05;
		i_axi[p].awaddr <= 32'h4000_00a8;
		i_axi[p].awlen <= 8'h00;
		i_axi[p].wvalid <= 1'b1;
		i_axi[p].wdata <= 32'hff00_f00f;
		i_axi[p].wstrb <= 4'hf;
		i_axi[p].wlast <= 1'b1;
		i_axi[p].bready <= 1'b1;
		for (int i = 0; i < 200 && !got; i++) begin
			@(posedge i_clock);
			if (o_axi[p].awready) i_axi[p].awvalid <= 1'b0;
			if (o_axi[p].wready) i_axi[p].wvalid <= 1'b0;
			if (o_pad.cs_n != 4'hf) begin
				cs = o_pad.cs_n;
				if (o_pad.ca == `LPM_CA_WRITE) cmd = 1;
				else a = o_pad.ca;
			end
			if (o_pad.dq_oe_n[0] == 1'b0) begin
				dq = o_pad.dq;
				oe = o_pad.dq_oe_n;
				mk = o_pad.mem_mask_invert;
				mo = o_pad.mask_oe_n;
				so = o_pad.dqs_oe_n;
			end
			if (o_axi[p].bvalid === 1'b1) begin
				got = 1;
				check("bid", o_axi[p].bid, 6'h05);
				check("bresp", o_axi[p].bresp, 2'h0);
			end
		end
		if (!got) timed_out();
		i_axi[p].bready <= 1'b0;
		check("ca cmd", cmd, 1);
		check("ca addr", a, 6'h2a);
		check("cs_n", cs, 4'hd);
		check("dq", dq & keep, exp_dq & keep);
		check("mask", mk & lanes, exp_mask & lanes);
		check("dqs_oe_n", so, lanes ^ 4'hf);
		check("dq_oe_n", oe, ~keep);
		check("mask_oe_n", mo, wide ? 4'h0 : 4'hc);
	endtask : write_case
	// Read beat returned inverted on lanes 0 and 2
	task automatic read_case;
		logic got;
		got = 0;
		@(posedge i_clock);
		i_wide <= 1'b1;
		i_dbi_rd_en <= 1'b1;
		mem_word <= 32'h1234_00ff;
		mem_inv <= 4'h5;
		mem_start <= 1'b1;
		i_axi[0].arvalid <= 1'b1;
		i_axi[0].arid <= 6'h09;
		i_axi[0].araddr <= 32'h0000_0040;
		i_axi[0].arlen <= 8'h00;
		i_axi[0].rready <= 1'b1;
		for (int i = 0; i < 300 && !got; i++) begin
			@(posedge i_clock);
			if (o_axi[0].arready) i_axi[0].arvalid <= 1'b0;
			if (o_axi[0].rvalid === 1'b1) begin
				got = 1;
				check("rdata", o_axi[0].rdata, 32'h1234_00ff);
				check("rlast", o_axi[0].rlast, 1'b1);
				check("rid", o_axi[0].rid, 6'h09);
				check("rresp", o_axi[0].rresp, 2'h0);
			end
		end
		if (!got) timed_out();
		i_axi[0].rready <= 1'b0;
		mem_start <= 1'b0;
	endtask : read_case
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_rst = 1'b1;
		i_wide = 1'b1;
		i_dbi_wr_en = 1'b0;
		i_dbi_rd_en = 1'b0;
		i_mem_reset_req = 1'b1;
		i_cke_req = 2'h0;
		i_axi[0] = '0;
		i_axi[1] = '0;
		mem_start = 1'b0;
		mem_word = 32'h0000_0000;
		mem_inv = 4'h0;
		reset_case();
		ctrl_case();
		clock_case();
		write_case(0, 1'b1, 1'b1, 32'h0000_f00f, 4'h8);
		write_case(0, 1'b1, 1'b0, 32'hff00_f00f, 4'h0);
		write_case(1, 1'b0, 1'b1, 32'h0000_f00f, 4'h0);
		read_case();
		reset_case();
		complete_run();
	end
endmodule : tb_lpm_pads
`default_nettype wire
